// [core/pcd_params.svh]
/*
  Timing counts, limits and reset values for the pedestrian countdown timer.
  Assumes a 25 MHz clock; long counts are overridable by top-level parameters.
*/
`ifndef PCD_PARAMS_SVH
`define PCD_PARAMS_SVH

// Clock period in ns
`define PCD_CLK_PERIOD_NS 40
// One display second
`define PCD_SECOND_MS 1000
`define PCD_SECOND_CYCLES ((`PCD_SECOND_MS * 1000000) / `PCD_CLK_PERIOD_NS)
// Indication debounce, a least time, so rounded up
`define PCD_DEBOUNCE_MS 20
`define PCD_DEBOUNCE_CYCLES \
  (((`PCD_DEBOUNCE_MS * 1000000) + `PCD_CLK_PERIOD_NS - 1) / `PCD_CLK_PERIOD_NS)
// Supply interruption that forces a dark cycle, rounded up
`define PCD_POWER_LOSS_MS 1500
`define PCD_POWER_LOSS_CYCLES \
  (((`PCD_POWER_LOSS_MS * 1000000) + `PCD_CLK_PERIOD_NS - 1) / `PCD_CLK_PERIOD_NS)
// Largest count two digits can show
`define PCD_MAX_COUNT 7'h63
// Reset values
`define PCD_INTERVAL_RST 7'h00
`define PCD_SEG_RST 7'h00

`endif

// [core/pcd_pkg.sv]
/*
  Types shared by the pedestrian countdown timer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package pcd_pkg;
  // Controller phase as seen by the timer, Gray along idle, walk, clear
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_WALK = 2'h1,
    PH_CLEAR = 2'h3
  } phase_type;
  typedef logic [6:0] seg_type;
endpackage
`default_nettype wire

// [core/pcd_input_filter.sv]
/*
  Two-flop synchroniser and debounce for one controller pin.
  Assumes the pin is asynchronous to clk; reset is the synchronised copy.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pcd_params.svh"
module pcd_input_filter #(
  parameter int DEBOUNCE_CYCLES = `PCD_DEBOUNCE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pin in, clean level out
  input wire logic raw,
  output logic clean
);
  logic meta;
  logic sync;
  logic [19:0] stable_cnt;

  // Synchroniser; meta feeds only sync
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= 1'b0;
      sync <= 1'b0;
    end else begin
      meta <= raw;
      sync <= meta;
    end
  end

  // Accept a new level only after it has held for the debounce time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clean <= 1'b0;
      stable_cnt <= 20'h00000;
    end else if (sync == clean) begin
      stable_cnt <= 20'h00000;
    end else if (stable_cnt == 20'(DEBOUNCE_CYCLES - 1)) begin
      clean <= sync;
      stable_cnt <= 20'h00000;
    end else begin
      stable_cnt <= stable_cnt + 20'h00001;
    end
  end

  // A change passes only when stable long enough
  filter_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (clean != $past(clean)) |-> $past(stable_cnt) == 20'(DEBOUNCE_CYCLES - 1))
    else $error("filtered level changed before the debounce time");
endmodule
`default_nettype wire

// [core/ped_countdown_timer.sv]
/*
  Pedestrian countdown timer: watches walk, flashing-hand and steady-hand
  indications, learns the clearance interval and drives two digits.
  Assumes pins asynchronous to clk, a 25 MHz clock and nrst as power-on reset.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pcd_params.svh"
module ped_countdown_timer #(
  parameter int SECOND_CYCLES = `PCD_SECOND_CYCLES,
  parameter int DEBOUNCE_CYCLES = `PCD_DEBOUNCE_CYCLES,
  parameter int POWER_LOSS_CYCLES = `PCD_POWER_LOSS_CYCLES
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic nrst,
  // Controller indications
  input wire logic walk_pin,
  input wire logic flash_pin,
  input wire logic steady_pin,
  // Supply monitor, high while supply is good
  input wire logic power_ok_pin,
  // Display
  output pcd_pkg::seg_type seg_tens,
  output pcd_pkg::seg_type seg_ones,
  output logic digits_on,
  output logic dimming_enable
);
  logic nrst_meta;
  logic nrst_sync;
  logic [3:0] raw_pins;
  logic [3:0] clean;
  logic walk;
  logic flash;
  logic steady;
  logic power_ok;
  logic flash_d;
  logic all_dark;
  logic flash_rise;
  logic end_cycle;
  logic stop_clear;
  pcd_pkg::phase_type phase;
  logic from_walk;
  logic [24:0] sub_cnt;
  logic [6:0] elapsed;
  logic [6:0] measured;
  logic [6:0] remaining;
  logic [6:0] interval;
  logic learned;
  logic mute;
  logic [6:0] cand;
  logic cand_valid;
  logic [25:0] low_cnt;
  logic power_lost;
  logic show;

  // Segment pattern gfedcba for one decimal digit
  function automatic pcd_pkg::seg_type seg_encode(input logic [3:0] d);
    unique case (d)
      4'h0: seg_encode = 7'h3F;
      4'h1: seg_encode = 7'h06;
      4'h2: seg_encode = 7'h5B;
      4'h3: seg_encode = 7'h4F;
      4'h4: seg_encode = 7'h66;
      4'h5: seg_encode = 7'h6D;
      4'h6: seg_encode = 7'h7D;
      4'h7: seg_encode = 7'h07;
      4'h8: seg_encode = 7'h7F;
      4'h9: seg_encode = 7'h6F;
      default: seg_encode = 7'h00;
    endcase
  endfunction

  // Reset release through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nrst_meta <= 1'b0;
      nrst_sync <= 1'b0;
    end else begin
      nrst_meta <= 1'b1;
      nrst_sync <= nrst_meta;
    end
  end

  // Every pin is synchronised and debounced; nothing else reads the pins
  assign raw_pins = {power_ok_pin, steady_pin, flash_pin, walk_pin};
  generate
    for (genvar i = 0; i < 4; i++) begin : g_filt
      pcd_input_filter #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_filt (
        .clk(clk),
        .nrst(nrst_sync),
        .raw(raw_pins[i]),
        .clean(clean[i])
      );
    end
  endgenerate
  assign walk = clean[0];
  assign flash = clean[1];
  assign steady = clean[2];
  assign power_ok = clean[3];

  // Indication events
  assign flash_rise = flash && !flash_d;
  assign all_dark = !walk && !flash && !steady;
  assign stop_clear = (phase == pcd_pkg::PH_CLEAR) && (steady || all_dark);
  assign end_cycle = (phase == pcd_pkg::PH_CLEAR) && steady && from_walk;

  always_ff @(posedge clk or negedge nrst_sync) begin
    if (!nrst_sync) begin
      flash_d <= 1'b0;
    end else begin
      flash_d <= flash;
    end
  end

  // Phase tracking; the only inputs are the controller's indications
  always_ff @(posedge clk or negedge nrst_sync) begin
    if (!nrst_sync) begin
      phase <= pcd_pkg::PH_IDLE;
      from_walk <= 1'b0;
    end else begin
      unique case (phase)
        pcd_pkg::PH_IDLE: begin
          if (flash_rise) begin
            phase <= pcd_pkg::PH_CLEAR; // Partial cycle, never learned from
            from_walk <= 1'b0;
          end else if (walk) begin
            phase <= pcd_pkg::PH_WALK;
          end
        end
        pcd_pkg::PH_WALK: begin
          if (flash_rise) begin
            phase <= pcd_pkg::PH_CLEAR; // Also a walk cut short
            from_walk <= 1'b1;
          end else if (steady || all_dark) begin
            phase <= pcd_pkg::PH_IDLE;
          end
        end
        pcd_pkg::PH_CLEAR: begin
          if (stop_clear) begin
            phase <= pcd_pkg::PH_IDLE;
          end
        end
        default: phase <= pcd_pkg::PH_IDLE;
      endcase
    end
  end

  // Seconds into the clearance; cleared once steady hand or dark ends it
  always_ff @(posedge clk or negedge nrst_sync) begin
    if (!nrst_sync) begin
      sub_cnt <= 25'h0000000;
      elapsed <= 7'h00;
    end else if (phase != pcd_pkg::PH_CLEAR) begin
      sub_cnt <= 25'h0000000;
      elapsed <= 7'h00;
    end else if (sub_cnt == 25'(SECOND_CYCLES - 1)) begin
      sub_cnt <= 25'h0000000;
      if (elapsed != `PCD_MAX_COUNT) begin
        elapsed <= elapsed + 7'h01; // Saturates at two digits
      end
    end else begin
      sub_cnt <= sub_cnt + 25'h0000001;
    end
  end

  // Whole seconds, nearest; shown count is interval minus elapsed, i.e. rounded up
  assign measured = (sub_cnt >= 25'(SECOND_CYCLES / 2) && elapsed != `PCD_MAX_COUNT) ?
                    elapsed + 7'h01 : elapsed;
  assign remaining = (interval > elapsed) ? interval - elapsed : 7'h00; // Holds at 0

  // Supply watch; short dips are ignored
  always_ff @(posedge clk or negedge nrst_sync) begin
    if (!nrst_sync) begin
      low_cnt <= 26'h0000000;
    end else if (power_ok) begin
      low_cnt <= 26'h0000000;
    end else if (!power_lost) begin
      low_cnt <= low_cnt + 26'h0000001;
    end
  end
  assign power_lost = !power_ok && (low_cnt == 26'(POWER_LOSS_CYCLES - 1));

  // Learning. A single shorter cycle is taken as preemption; only a second
  // identical one counts as a real change, trading one cycle of latency.
  always_ff @(posedge clk or negedge nrst_sync) begin
    if (!nrst_sync) begin
      interval <= `PCD_INTERVAL_RST;
      learned <= 1'b0; // Power-on learning cycle
      mute <= 1'b1;
      cand <= `PCD_INTERVAL_RST;
      cand_valid <= 1'b0;
    end else if (power_lost) begin
      mute <= 1'b1; // One dark cycle after a long loss
    end else if (end_cycle) begin
      if (!learned || mute) begin
        interval <= measured; // Dark cycle complete, store it
        learned <= 1'b1;
        mute <= 1'b0;
        cand_valid <= 1'b0;
      end else if (measured > interval) begin
        mute <= 1'b1; // Lengthened timing
        cand_valid <= 1'b0;
      end else if (measured < interval) begin
        if (cand_valid && cand == measured) begin
          mute <= 1'b1; // Shortened timing confirmed
          cand_valid <= 1'b0;
        end else begin
          cand <= measured; // Treated as preemption, interval kept
          cand_valid <= 1'b1;
        end
      end else begin
        cand_valid <= 1'b0;
      end
    end
  end

  // Display shown only in a learned, unmuted clearance
  assign show = (phase == pcd_pkg::PH_CLEAR) && !stop_clear && learned && !mute && power_ok;

  always_ff @(posedge clk or negedge nrst_sync) begin
    if (!nrst_sync) begin
      digits_on <= 1'b0;
      seg_tens <= `PCD_SEG_RST;
      seg_ones <= `PCD_SEG_RST;
    end else if (show) begin
      digits_on <= 1'b1;
      seg_tens <= seg_encode(4'(remaining / 7'h0A));
      seg_ones <= seg_encode(4'(remaining % 7'h0A));
    end else begin
      digits_on <= 1'b0;
      seg_tens <= `PCD_SEG_RST;
      seg_ones <= `PCD_SEG_RST;
    end
  end

  // Dimming held off so light output stays constant
  always_ff @(posedge clk or negedge nrst_sync) begin
    if (!nrst_sync) begin
      dimming_enable <= 1'b0;
    end else begin
      dimming_enable <= 1'b0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst_sync);

  learn_dark_a: assert property (!learned |=> !digits_on)
    else $error("digits lit before the first learned interval");
  mute_dark_a: assert property (mute |=> !digits_on)
    else $error("digits lit during a relearning cycle");
  early_stop_a: assert property (stop_clear |=> phase == pcd_pkg::PH_IDLE ##0 !digits_on)
    else $error("timing did not stop at steady hand or dark outputs");
  walk_preempt_a: assert property (
    (phase == pcd_pkg::PH_WALK && flash_rise) |=> phase == pcd_pkg::PH_CLEAR && elapsed == 7'h00)
    else $error("flashing hand after walk did not start the count");
  no_restart_a: assert property (
    (phase == pcd_pkg::PH_CLEAR && !stop_clear) |=> elapsed >= $past(elapsed))
    else $error("count restarted during flashing hand");
  keep_interval_a: assert property (
    (end_cycle && learned && !mute && !power_lost && measured < interval && !cand_valid)
    |=> interval == $past(interval) && !mute ##1 cand_valid)
    else $error("single short cycle was treated as a timing change");
  power_mute_a: assert property (power_lost |=> mute ##1 !digits_on)
    else $error("long supply loss did not darken the next cycle");
  two_digit_a: assert property (interval <= `PCD_MAX_COUNT && elapsed <= `PCD_MAX_COUNT)
    else $error("count exceeds two digits");
  dim_off_a: assert property (digits_on |-> !dimming_enable)
    else $error("dimming active while lit");
  shown_count_a: assert property (
    show |=> digits_on && seg_ones == seg_encode(4'($past(remaining) % 7'h0A)))
    else $error("shown digit differs from remaining seconds");
  count_start_a: assert property (
    (phase == pcd_pkg::PH_CLEAR && $past(phase) != pcd_pkg::PH_CLEAR) |-> elapsed == 7'h00)
    else $error("countdown did not start from the full interval");
endmodule
`default_nettype wire

// [verification/ped_ctrl_model.sv]
/*
  Signal controller model: drives walk, flashing-hand and steady-hand levels.
  Assumes the bench clock; pins change 1 ns after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module ped_ctrl_model (
  // Clock
  input wire logic clk,
  // Indications to the timer
  output logic walk_pin,
  output logic flash_pin,
  output logic steady_pin
);
  // All indications dark until the first cycle
  initial begin
    walk_pin = 1'b0;
    flash_pin = 1'b0;
    steady_pin = 1'b0;
  end

  // Wait n edges, then step just past the last one
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One cycle; a short walk is a preempted walk that still leads to flash
  task automatic cycle(input int w, input int f, input bit dark);
    steady_pin = 1'b0;
    walk_pin = 1'b1;
    hold(w);
    walk_pin = 1'b0;
    flash_pin = 1'b1;
    hold(f);
    flash_pin = 1'b0;
    steady_pin = !dark;
    // Long enough for the timer's filter to take the end level
    hold(20);
  endtask

  // Flash blip shorter than the timer's debounce
  task automatic glitch();
    flash_pin = 1'b1;
    hold(2);
    flash_pin = 1'b0;
    hold(20);
  endtask
endmodule
`default_nettype wire

// [verification/pedestrian_countdown_timer_bench.sv]
/*
  Bench for the countdown timer: controller model on the pins, expected
  displays queued by the stimulus and checked by a watcher process.
  Assumes the timer's short simulation counts set below.
*/
`timescale 1ns/100ps
`default_nettype none
module pedestrian_countdown_timer_bench;
  localparam int SEC = 50;
  logic clk, nrst, walk_pin, flash_pin, steady_pin, power_ok_pin;
  pcd_pkg::seg_type seg_tens, seg_ones;
  logic digits_on, dimming_enable;
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 96;
  logic [14:0] exp_q [$];
  logic [14:0] shown;
  logic [14:0] last_shown = 15'h0000;
  pcd_pkg::seg_type code [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66,
    7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};

  ped_countdown_timer #(.SECOND_CYCLES(SEC), .DEBOUNCE_CYCLES(4),
    .POWER_LOSS_CYCLES(200)) i_ped_countdown_timer (.clk(clk), .nrst(nrst),
    .walk_pin(walk_pin), .flash_pin(flash_pin), .steady_pin(steady_pin),
    .power_ok_pin(power_ok_pin), .seg_tens(seg_tens), .seg_ones(seg_ones),
    .digits_on(digits_on), .dimming_enable(dimming_enable));
  ped_ctrl_model i_ped_ctrl_model (.clk(clk), .walk_pin(walk_pin),
    .flash_pin(flash_pin), .steady_pin(steady_pin));

  assign shown = {digits_on, seg_tens, seg_ones};

  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [14:0] seen, input logic [14:0] want);
    n_compared++;
    if (seen !== want) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watcher: every new display state must be the oldest queued one
  always @(negedge clk) begin
    if (shown !== last_shown) begin
      // Nothing queued means no change is due, so the old state is expected
      if (exp_q.size() == 0) begin
        check(shown, last_shown);
      end else begin
        check(shown, exp_q.pop_front());
      end
      last_shown = shown;
    end
  end

  // Queue counts hi down to lo, then the dark state
  task automatic expect_count(input int hi, input int lo);
    for (int c = hi; c >= lo; c--)
      exp_q.push_back({1'b1, code[c / 10], code[c % 10]});
    exp_q.push_back(15'h0000);
  endtask

  // Bounded wait for every queued display to show up
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    #1;
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("mismatch at %0t: display missing", $time);
      finish_test();
    end
  endtask

  // One controller cycle with f and a quarter seconds of flashing hand; hi < 0 means dark
  task automatic ped(input int f, input int hi, input int lo, input bit dark);
    if (hi >= 0)
      expect_count(hi, lo);
    i_ped_ctrl_model.cycle(10 + ($random(seed) & 15), f * SEC + SEC / 4, dark);
    drain();
  endtask

  task automatic done(input string name);
    check({14'h0000, dimming_enable}, 15'h0000);
    $display("%s finished, mismatches so far %0d", name, error_cnt);
  endtask

  // Supply low for n cycles, then time to settle
  task automatic power_dip(input int n);
    power_ok_pin = 1'b0;
    i_ped_ctrl_model.hold(n);
    power_ok_pin = 1'b1;
    i_ped_ctrl_model.hold(20);
  endtask

  initial begin
    nrst = 1'b0;
    power_ok_pin = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
    i_ped_ctrl_model.hold(20);
    ped(5, -1, 0, 0);
    ped(5, 5, 0, 0);
    done("learning");
    ped(3, 5, 2, 0);
    ped(5, 5, 0, 0);
    done("preemption");
    ped(2, 5, 3, 1);
    ped(5, 5, 0, 0);
    done("all dark");
    i_ped_ctrl_model.glitch();
    ped(5, 5, 0, 0);
    done("glitch");
    // Flash with no walk before it: counts the stored interval, never learned
    expect_count(5, 0);
    i_ped_ctrl_model.cycle(0, 7 * SEC + SEC / 4, 0);
    drain();
    ped(5, 5, 0, 0);
    done("flash without walk");
    ped(7, 5, 0, 0);
    ped(7, -1, 0, 0);
    ped(7, 7, 0, 0);
    done("longer");
    ped(4, 7, 3, 0);
    ped(4, 7, 3, 0);
    ped(4, -1, 0, 0);
    ped(4, 4, 0, 0);
    done("shorter");
    power_dip(100);
    ped(4, 4, 0, 0);
    power_dip(300);
    ped(4, -1, 0, 0);
    ped(4, 4, 0, 0);
    done("power loss");
    finish_test();
  end
endmodule
`default_nettype wire
